// file: core/pbl_top.sv
// PRBS self-test generator, checker, counter and loopback select
`default_nettype none
module pbl_top
    import pbl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Transmit datapath
    output logic [7:0] tx_data,
    output logic tx_valid,
    // Receive datapath, same clock
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    // Loopback steering and events
    output pbl_loop_s loop_cfg,
    output logic err_wrap_pulse,
    output logic irq
);

    // One PRBS-7 step per bit, eight bits a byte
    function automatic logic [6:0] prbs_byte(input logic [6:0] s);
        logic [6:0] r;
        r = s;
        for (int i = 0; i < 8; i++) begin
            r = {r[5:0], r[6] ^ r[5]};
        end
        return r;
    endfunction

    // Bitwise mismatch count for one byte
    function automatic logic [3:0] pop8(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++) begin
            c = c + {3'b000, v[i]};
        end
        return c;
    endfunction

    logic [15:0] ctrl_ff, nxt_ctrl;
    logic sync_loss_ff, nxt_sync_loss;
    logic [15:0] err_ff, nxt_err;
    logic [2:0] ista_ff, nxt_ista;
    logic [2:0] imsk_ff, nxt_imsk;
    logic [31:0] dat_ff, nxt_dat;
    logic ack_ff, nxt_ack;
    pbl_gen_e gst_ff, nxt_gst;
    logic [10:0] cnt_ff, nxt_cnt;
    logic [6:0] gsr_ff, nxt_gsr;
    logic [7:0] txd_ff, nxt_txd;
    logic txv_ff, nxt_txv;
    logic [6:0] csr_ff, nxt_csr;
    logic lock_ff, nxt_lock;
    logic [3:0] good_ff, nxt_good;
    logic [3:0] bad_ff, nxt_bad;
    logic wrap_ff, nxt_wrap;
    logic irq_ff, nxt_irq;
    pbl_loop_s loop_ff, nxt_loop;

    logic acc, wr, rd;
    logic [15:0] rd_ctrl;
    logic [6:0] exp_bits;
    logic [3:0] nerr;
    logic [16:0] sum;
    logic chk_en, done_ev, loss_ev, wrap_ev;

    assign acc = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr = acc && wb_we_i;
    assign rd = acc && !wb_we_i;
    // Checker runs for PRBS type whether or not the generator is on
    assign chk_en = ctrl_ff[B_PKT_TYPE];
    assign rd_ctrl = (ctrl_ff & CTRL_WMASK) | CTRL_RSVD
        | (16'(lock_ff) << B_LOCK) | (16'(sync_loss_ff) << B_SYNC_LOSS)
        | (16'(gst_ff == GEN_RUN) << B_GEN_STAT);

    // Register file and bus answer
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_imsk = imsk_ff;
        nxt_dat = dat_ff;
        nxt_ack = acc;
        nxt_ista = ista_ff | {done_ev, loss_ev, wrap_ev};
        if (wr && wb_sel_i[0] && wb_adr_i == ADR_CTRL) begin
            nxt_ctrl[7:0] = wb_dat_i[7:0] & CTRL_WMASK[7:0];
        end
        if (wr && wb_sel_i[1] && wb_adr_i == ADR_CTRL) begin
            nxt_ctrl[15:8] = wb_dat_i[15:8] & CTRL_WMASK[15:8];
        end
        // Line bit only sticks while a loopback path is chosen
        if (nxt_ctrl[B_LB_LO +: 4] == LB_NORMAL) begin
            nxt_ctrl[B_LINE_TX] = 1'b0;
        end
        if (wr && wb_sel_i[0] && wb_adr_i == ADR_IRQ_MASK) begin
            nxt_imsk = wb_dat_i[2:0];
        end
        // Write one to clear; a new event in the same cycle wins
        if (wr && wb_sel_i[0] && wb_adr_i == ADR_IRQ_STAT) begin
            nxt_ista = (ista_ff & ~wb_dat_i[2:0]) | {done_ev, loss_ev, wrap_ev};
        end
        case (wb_adr_i)
            ADR_CTRL: nxt_dat = {16'h0000, rd_ctrl};
            ADR_ERRCNT: nxt_dat = {16'h0000, err_ff};
            ADR_IRQ_STAT: nxt_dat = {29'h0, ista_ff};
            ADR_IRQ_MASK: nxt_dat = {29'h0, imsk_ff};
            default: nxt_dat = 32'h0;
        endcase
        if (!rd) begin
            nxt_dat = 32'h0;
        end
        nxt_irq = |(nxt_ista & nxt_imsk);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= 16'h0;
            imsk_ff <= 3'h0;
            ista_ff <= 3'h0;
            dat_ff <= 32'h0;
            ack_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            imsk_ff <= nxt_imsk;
            ista_ff <= nxt_ista;
            dat_ff <= nxt_dat;
            ack_ff <= nxt_ack;
            irq_ff <= nxt_irq;
        end
    end

    // Packet generator
    always_comb begin
        nxt_gst = gst_ff;
        nxt_cnt = cnt_ff;
        nxt_gsr = gsr_ff;
        nxt_txd = 8'h00;
        nxt_txv = 1'b0;
        done_ev = 1'b0;
        case (gst_ff)
            GEN_IDLE: begin
                if (ctrl_ff[B_GEN_EN]) begin
                    nxt_gst = GEN_RUN;
                    nxt_cnt = 11'h0;
                end
            end
            GEN_RUN: begin
                nxt_txv = 1'b1;
                nxt_cnt = cnt_ff + 11'h1;
                if (ctrl_ff[B_PKT_TYPE]) begin
                    nxt_gsr = prbs_byte(gsr_ff);
                    nxt_txd = {gsr_ff, gsr_ff[6]};
                end else begin
                    nxt_txd = CONST_BYTE;
                end
                if (cnt_ff == PKT_LEN - 11'h1) begin
                    nxt_cnt = 11'h0;
                    // Back to back for PRBS, else stop after one
                    if (!ctrl_ff[B_PKT_TYPE]) begin
                        nxt_gst = GEN_DONE;
                        done_ev = 1'b1;
                    end
                end
                if (!ctrl_ff[B_GEN_EN]) begin
                    nxt_gst = GEN_IDLE;
                    nxt_txv = 1'b0;
                end
            end
            GEN_DONE: begin
                // Rearm needs the enable bit cleared first
                if (!ctrl_ff[B_GEN_EN]) begin
                    nxt_gst = GEN_IDLE;
                end
            end
            default: nxt_gst = GEN_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gst_ff <= GEN_IDLE;
            cnt_ff <= 11'h0;
            gsr_ff <= 7'h7f;
            txd_ff <= 8'h00;
            txv_ff <= 1'b0;
        end else begin
            gst_ff <= nxt_gst;
            cnt_ff <= nxt_cnt;
            gsr_ff <= nxt_gsr;
            txd_ff <= nxt_txd;
            txv_ff <= nxt_txv;
        end
    end

    // Checker: seeds from received data, then predicts each byte
    assign exp_bits = prbs_byte(csr_ff);
    assign nerr = pop8(rx_data ^ {exp_bits, exp_bits[6]});
    assign sum = {1'b0, err_ff} + {13'h0, nerr};
    assign loss_ev = lock_ff && !nxt_lock;

    always_comb begin
        nxt_csr = csr_ff;
        nxt_lock = lock_ff;
        nxt_good = good_ff;
        nxt_bad = bad_ff;
        nxt_err = err_ff;
        nxt_wrap = 1'b0;
        wrap_ev = 1'b0;
        if (!chk_en) begin
            nxt_lock = 1'b0;
            nxt_good = 4'h0;
            nxt_bad = 4'h0;
        end else if (rx_valid) begin
            nxt_csr = rx_data[7:1];
            if (!lock_ff) begin
                nxt_good = (nerr == 4'h0) ? good_ff + 4'h1 : 4'h0;
                if (good_ff == LOCK_CNT - 4'h1 && nerr == 4'h0) begin
                    nxt_lock = 1'b1;
                    nxt_bad = 4'h0;
                end
            end else begin
                nxt_csr = exp_bits;
                // Count every bit mismatch while locked
                if (nerr != 4'h0) begin
                    nxt_bad = bad_ff + 4'h1;
                    if (sum > {1'b0, ERR_MAX}) begin
                        if (ctrl_ff[B_CNT_MODE]) begin
                            // Roll over past the maximum; the count keeps the low 16 bits of the sum
                            nxt_err = sum[15:0];
                            nxt_wrap = 1'b1;
                            wrap_ev = 1'b1;
                        end else begin
                            nxt_err = ERR_MAX;
                        end
                    end else begin
                        nxt_err = sum[15:0];
                    end
                end else begin
                    nxt_bad = 4'h0;
                end
                if (bad_ff == LOSS_CNT - 4'h1 && nerr != 4'h0) begin
                    nxt_lock = 1'b0;
                    nxt_good = 4'h0;
                end
            end
        end
        // Latched loss clears on read; a fresh loss wins
        nxt_sync_loss = sync_loss_ff;
        if (rd && wb_adr_i == ADR_CTRL) begin
            nxt_sync_loss = 1'b0;
        end
        if (loss_ev) begin
            nxt_sync_loss = 1'b1;
        end
        // Loopback select and line transmit gate
        nxt_loop.lb_sel = ctrl_ff[B_LB_LO +: 4];
        nxt_loop.line_tx = ctrl_ff[B_LINE_TX] && (ctrl_ff[B_LB_LO +: 4] != LB_NORMAL);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            csr_ff <= 7'h0;
            lock_ff <= 1'b0;
            good_ff <= 4'h0;
            bad_ff <= 4'h0;
            err_ff <= 16'h0;
            wrap_ff <= 1'b0;
            sync_loss_ff <= 1'b0;
            loop_ff <= '0;
        end else begin
            csr_ff <= nxt_csr;
            lock_ff <= nxt_lock;
            good_ff <= nxt_good;
            bad_ff <= nxt_bad;
            err_ff <= nxt_err;
            wrap_ff <= nxt_wrap;
            sync_loss_ff <= nxt_sync_loss;
            loop_ff <= nxt_loop;
        end
    end

    assign wb_dat_o = dat_ff;
    assign wb_ack_o = ack_ff;
    assign tx_data = txd_ff;
    assign tx_valid = txv_ff;
    assign loop_cfg = loop_ff;
    assign err_wrap_pulse = wrap_ff;
    assign irq = irq_ff;

endmodule
`default_nettype wire

// file: core/pbl_pkg.sv
// Package for the PRBS self-test and loopback control block
// Behaviour
// - Continuous mode: pulse at max, wrap, continue
// - Single mode: counter holds at maximum
// - Type one, enabled: continuous PRBS packets
// - Type one, generator off: checker stays enabled
// - Type zero: one constant packet, no PRBS
// - Enable bit starts or stops the generator
// - Lock bit shows checker synchronized
// - Sync loss latched high until read
// - Status bit shows generator producing packets
// - Loopback 0000 normal, 0001 PCS, 0010 analog
// - 0100 reverse loopback; 1000 reserved
// - Bit six sends looped data to line
`default_nettype none
package pbl_pkg;
    // Register byte addresses
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_ERRCNT = 4'h4;
    localparam logic [3:0] ADR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADR_IRQ_MASK = 4'hc;
    // Control field positions
    localparam int B_CNT_MODE = 14;
    localparam int B_PKT_TYPE = 13;
    localparam int B_GEN_EN = 12;
    localparam int B_LOCK = 11;
    localparam int B_SYNC_LOSS = 10;
    localparam int B_GEN_STAT = 9;
    localparam int B_LINE_TX = 6;
    localparam int B_LB_LO = 2;
    localparam logic [15:0] CTRL_WMASK = 16'h707f;
    localparam logic [15:0] CTRL_RSVD = 16'h0100;
    // Loopback encodings
    localparam logic [3:0] LB_NORMAL = 4'h0;
    localparam logic [3:0] LB_PCS = 4'h1;
    localparam logic [3:0] LB_ANALOG = 4'h2;
    localparam logic [3:0] LB_REVERSE = 4'h4;
    // Packet and checker sizing
    localparam logic [10:0] PKT_LEN = 11'h5ea;
    localparam logic [15:0] ERR_MAX = 16'hffff;
    localparam logic [3:0] LOCK_CNT = 4'hf;
    localparam logic [3:0] LOSS_CNT = 4'h8;
    localparam logic [7:0] CONST_BYTE = 8'ha5;
    // Interrupt bits
    localparam int IRQ_WRAP = 0;
    localparam int IRQ_LOSS = 1;
    localparam int IRQ_DONE = 2;

    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00,
        GEN_RUN = 2'b01,
        GEN_DONE = 2'b10
    } pbl_gen_e;

    typedef struct packed {
        logic [3:0] lb_sel;
        logic line_tx;
    } pbl_loop_s;
endpackage
`default_nettype wire

// file: testbench/pbl_top_asserts.sv
// Concurrent checks on the ports of the self-test block
`default_nettype none
module pbl_top_asserts
    import pbl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Datapath and events
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire pbl_loop_s loop_cfg,
    input wire logic err_wrap_pulse,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ctrl_wr;
    // Control write at its ack edge, request still held by the master
    assign ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i == ADR_CTRL;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not acked");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    property p_ctrl_fixed; wb_ack_o && !wb_we_i && wb_adr_i == ADR_CTRL |-> wb_dat_o[8]; endproperty
    a_ctrl_fixed: assert property (p_ctrl_fixed) else $error("fixed control bit wrong");
    property p_loop_copy; ctrl_wr && wb_sel_i[0] |=> loop_cfg.lb_sel == $past(wb_dat_i[5:2]); endproperty
    a_loop_copy: assert property (p_loop_copy) else $error("loop select stale");
    property p_line_gate; loop_cfg.line_tx |-> loop_cfg.lb_sel != LB_NORMAL; endproperty
    a_line_gate: assert property (p_line_gate) else $error("line tx outside loop");
    property p_gen_start; ctrl_wr && wb_sel_i[1] && wb_dat_i[12] && wb_dat_i[13] |-> ##2 tx_valid;
    endproperty
    a_gen_start: assert property (p_gen_start) else $error("generator silent");
    property p_wrap_pulse; err_wrap_pulse |=> !err_wrap_pulse; endproperty
    a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse too long");
endmodule
bind pbl_top pbl_top_asserts u_chk (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_data(tx_data),
    .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .loop_cfg(loop_cfg),
    .err_wrap_pulse(err_wrap_pulse), .irq(irq));
`default_nettype wire

// file: testbench/pbl_link_model.sv
// Line-side loopback model with bit error injection
`default_nettype none
module pbl_link_model
    import pbl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Block transmit side and loop steering
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire pbl_loop_s loop_cfg,
    // Error injection
    input wire logic [7:0] flip,
    input wire logic burst,
    // Block receive side
    output logic [7:0] rx_data,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_ff;
    // Bytes return one clock later only while a loop path is chosen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            cnt_ff <= 3'h0;
        end else if (tx_valid && loop_cfg.lb_sel != LB_NORMAL) begin
            cnt_ff <= cnt_ff + 3'h1;
            // Burst spoils seven bytes of eight, short of a sync loss
            rx_data <= tx_data ^ flip ^ ((burst && cnt_ff != 3'h7) ? 8'hff : 8'h00);
            rx_valid <= 1'b1;
        end else begin
            rx_data <= ~rx_data; // Stale byte never looks fresh
            rx_valid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the self-test and loopback block
`default_nettype none
module testbench
    import pbl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, burst = 0;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, exp_q[$], msk_q[$], e, m;
    logic [7:0] tx_data, rx_data, flip = 0, f;
    logic tx_valid, rx_valid, err_wrap_pulse, irq, wb_ack_o;
    pbl_loop_s loop_cfg;
    logic [3:0] lbs[4] = '{LB_NORMAL, LB_PCS, LB_ANALOG, LB_REVERSE};
    int num_errors = 0, total_checks = 0, wraps = 0, n, bad, cnt;
    integer seed = 11;
    pbl_top i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_data(tx_data), .tx_valid(tx_valid),
        .rx_data(rx_data), .rx_valid(rx_valid), .loop_cfg(loop_cfg),
        .err_wrap_pulse(err_wrap_pulse), .irq(irq));
    pbl_link_model i_link (.clk(clk), .rst_b(rst_b), .tx_data(tx_data), .tx_valid(tx_valid),
        .loop_cfg(loop_cfg), .flip(flip), .burst(burst), .rx_data(rx_data), .rx_valid(rx_valid));
    always #10 clk = ~clk;
    task automatic check(string what, logic [31:0] x, logic [31:0] y);
        total_checks++;
        if (y !== x) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, x, y);
        end
    endtask
    // Classic single cycle; a read notes its expectation for the scoreboard
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d, logic [31:0] k);
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} <= {2'b11, w, a, 4'h3};
        wb_dat_i <= w ? d : 32'h0;
        if (!w) exp_q.push_back(d);
        if (!w) msk_q.push_back(k);
        @(posedge clk iff wb_ack_o);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    // Send one spoiled byte through the link
    task automatic spoil(logic [7:0] v);
        @(posedge clk iff tx_valid);
        flip <= v;
        @(posedge clk iff tx_valid);
        flip <= 8'h00;
    endtask
    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Scoreboard takes the oldest note at each read answer; wrap pulses counted
    always @(posedge clk) begin
        if (err_wrap_pulse) wraps++;
        if (wb_ack_o && !wb_we_i && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            check("read data", e & m, wb_dat_o & m);
        end
    end
    // Watchdog well beyond the expected run length
    initial begin
        #(80000 * 20);
        num_errors++;
        test_done();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        wb(0, ADR_CTRL, 32'h0100, 32'hffff);
        wb(1, ADR_ERRCNT, 32'h1234, 0);
        wb(0, ADR_ERRCNT, 0, 32'hffff);
        wb(1, 4'h2, 32'hffff, 0);
        wb(0, 4'h2, 0, 32'hffffffff);
        // Legal loop codes only, line transmit asked each time; 1000 stays unused
        foreach (lbs[i]) begin
            wb(1, ADR_CTRL, {25'h0, 1'b1, lbs[i], 2'h0}, 0);
            wb(0, ADR_CTRL, {25'h0, lbs[i] != 0, lbs[i], 2'h0}, 32'h7c);
        end
        // Single constant packet, then its done interrupt
        wb(1, ADR_IRQ_MASK, 32'h4, 0);
        wb(1, ADR_CTRL, 32'h1004, 0);
        n = 0;
        bad = 0;
        repeat (3000) begin
            @(posedge clk);
            if (tx_valid) n++;
            if (tx_valid && tx_data !== CONST_BYTE) bad++;
        end
        check("packet bytes", PKT_LEN, n);
        check("constant bytes", 0, bad);
        wb(0, ADR_CTRL, 32'h1004, 32'h1200);
        wb(0, ADR_ERRCNT, 0, 32'hffff);
        check("irq raised", 1, irq);
        wb(1, ADR_IRQ_MASK, 0, 0);
        repeat (2) @(posedge clk);
        check("irq masked", 0, irq);
        wb(1, ADR_IRQ_STAT, 32'h4, 0);
        wb(0, ADR_IRQ_STAT, 0, 32'h4);
        wb(1, ADR_IRQ_MASK, 32'h3, 0);
        // PRBS stream through the PCS loop, lock then counted bit errors
        wb(1, ADR_CTRL, 32'h0004, 0);
        wb(1, ADR_CTRL, 32'h3004, 0);
        repeat (200) @(posedge clk);
        wb(0, ADR_CTRL, 32'h3a04, 32'h3e00);
        cnt = 0;
        repeat (4) begin
            f = 8'($random(seed));
            f[0] = 1'b1;
            spoil(f);
            cnt += $countones(f);
            repeat (30) @(posedge clk);
        end
        wb(0, ADR_ERRCNT, cnt, 32'hffff);
        // Long bad run loses sync; flag holds until read
        flip <= 8'hff;
        repeat (12) @(posedge clk iff tx_valid);
        flip <= 8'h00;
        repeat (60) @(posedge clk);
        wb(0, ADR_CTRL, 32'h0400, 32'h0400);
        wb(0, ADR_CTRL, 32'h0800, 32'h0c00);
        wb(0, ADR_IRQ_STAT, 32'h2, 32'h2);
        check("irq loss", 1, irq);
        // Saturate in single mode, then wrap in continuous mode
        burst <= 1'b1;
        repeat (12000) @(posedge clk);
        burst <= 1'b0;
        repeat (60) @(posedge clk);
        wb(0, ADR_ERRCNT, 32'hffff, 32'hffff);
        check("no wrap", 0, wraps);
        wb(1, ADR_CTRL, 32'h7004, 0);
        spoil(8'h01);
        repeat (20) @(posedge clk);
        check("wrap pulses", 1, wraps);
        wb(0, ADR_ERRCNT, 0, 32'hffff);
        wb(0, ADR_IRQ_STAT, 32'h1, 32'h1);
        // Disable stops the generator
        wb(1, ADR_CTRL, 32'h6004, 0);
        repeat (1600) @(posedge clk);
        check("tx stopped", 0, tx_valid);
        wb(0, ADR_CTRL, 32'h6804, 32'h7a00);
        test_done();
    end
endmodule
`default_nettype wire
